// ---- dv/rtcs_host_model.sv ----
`timescale 1ns/1ps
module rtcs_host_model (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       irq_n_o,
    input  wire logic       irq_n_oe,
    input  wire logic       svc_en,
    input  wire logic [3:0] lat,
    output logic            irq_line,
    output logic [5:0]      clr
);
    int wait_cnt;

    // Pull-up on the shared wire: a released line reads high
    assign irq_line = irq_n_oe ? irq_n_o : 1'b1;

    // Service after lat cycles of request; the clear needs a few cycles to release the line
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= 0;
            clr      <= '0;
        end else begin
            clr <= '0;
            if (svc_en && !irq_line && clr == '0) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= lat) begin
                    clr      <= '1;
                    wait_cnt <= 0;
                end
            end else begin
                wait_cnt <= 0;
            end
        end
    end
endmodule : rtcs_host_model

// ---- dv/rtcs_irq_props.sv ----
`timescale 1ns/1ps
// Several ports share a line here so that the checker stays small
module rtcs_irq_props
    import rtcs_pkg::*;
(
    input wire logic       ref_clk, arst_n, clk_en, sec_inc, min_inc, alarm_event, tamper_mid_event,
    input wire logic       tamper_gnd_event, backup_switch_event, watchdog_expired, cell_low,
    input wire logic       slow_tick_irq_en, sec_tick_irq_en, alarm_irq_en, stamp_irq_en,
    input wire logic       backup_switch_irq_en, cell_low_irq_en, watchdog_irq_en,
    input wire logic       backup_event_stamp_en, clr_alarm, irq_n_o, irq_n_oe, tick_flag,
    input wire logic       alarm_flag, backup_switch_flag, watchdog_expired_flag, cell_low_flag,
    input wire logic [1:0] stamp_flags,
    input wire logic [7:0] cur_month,
    input wire logic [7:0] stamp_month_reg,
    input wire logic [7:0] stamp_year_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    wire lvl = (alarm_flag && alarm_irq_en) || ((|stamp_flags) && stamp_irq_en)
        || (backup_switch_flag && backup_switch_irq_en) || (cell_low_flag && cell_low_irq_en)
        || (watchdog_expired_flag && watchdog_irq_en);

    sequence s_sw_take;
        clk_en && backup_switch_event && backup_event_stamp_en && !backup_switch_flag;
    endsequence
    sequence s_sw_locked;
        clk_en && backup_event_stamp_en && backup_switch_flag
            && (tamper_mid_event || tamper_gnd_event || backup_switch_event);
    endsequence
    sequence s_sw_off;
        clk_en && !backup_event_stamp_en && backup_switch_event && !tamper_mid_event && !tamper_gnd_event;
    endsequence
    sequence s_held;
        ($stable(stamp_month_reg) && $stable(stamp_year_reg)) [*2];
    endsequence
    sequence s_alarm_clr;
        (clk_en && clr_alarm && !alarm_event) ##1 (!alarm_event) [*2];
    endsequence

    AST_OE_DRIVES_LOW: assert property (irq_n_oe |-> !irq_n_o)
        else $error("request driven high");
    AST_LEVEL_SRC: assert property (clk_en && lvl |=> irq_n_oe)
        else $error("level source not on request");
    AST_WDOG_FOLLOWS: assert property (clk_en |=> watchdog_expired_flag == $past(watchdog_expired))
        else $error("watchdog flag not following detector");
    AST_CELL_FOLLOWS: assert property (clk_en |=> cell_low_flag == $past(cell_low))
        else $error("cell low flag not following detector");
    AST_MONTH_UNUSED: assert property (stamp_month_reg[7:5] == 3'h0)
        else $error("month stamp unused bits set");
    AST_SWITCH_STAMP: assert property (s_sw_take |-> ##2 stamp_month_reg == ($past(cur_month, 2) & MONTH_USED_MASK))
        else $error("switch-over did not stamp");
    AST_SWITCH_FLAG: assert property (s_sw_take |=> backup_switch_flag)
        else $error("switch flag not set");
    AST_LOCKED: assert property (s_sw_locked |=> s_held)
        else $error("stamp changed while locked");
    AST_NO_SWITCH_STAMP: assert property (s_sw_off |=> s_held)
        else $error("stamp changed with stamping off");
    AST_TICK_NEVER: assert property (!slow_tick_irq_en && !sec_tick_irq_en |=> !$rose(tick_flag))
        else $error("tick flag set while disabled");
    AST_TICK_SEC: assert property (clk_en && sec_tick_irq_en && sec_inc |=> tick_flag)
        else $error("second tick not flagged");
    AST_TICK_MIN: assert property (clk_en && slow_tick_irq_en && !sec_tick_irq_en && min_inc |=> tick_flag)
        else $error("minute tick not flagged");
    AST_ALARM_CLEAR: assert property (s_alarm_clr |-> ##[0:1] !alarm_flag)
        else $error("alarm flag not cleared");
endmodule : rtcs_irq_props

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import rtcs_pkg::*;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (a), (b)); end end

    // One 64 Hz period shortened to TP cycles to keep the run short
    localparam int TP = 40;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        tick_64hz = 1'b0;
    logic [12:0] pl = '0;
    logic [7:0]  en = '0;
    logic [7:0]  cur_month = 8'h00;
    logic [7:0]  cur_year = 8'h00;
    logic [1:0]  lv = '0;
    logic [3:0]  lat = '0;
    logic        pmode = 1'b0;
    logic        bstamp = 1'b0;
    logic        keep = 1'b0;
    logic        svc = 1'b0;
    logic [5:0]  host_clr;
    logic        irq_line, irq_n_o, irq_n_oe, tick_flag, countdown_flag, alarm_flag;
    logic        backup_switch_flag, watchdog_expired_flag, cell_low_flag;
    logic [1:0]  stamp_flags;
    logic [7:0]  smon, syr, exp_m, exp_y;
    logic [4:0]  fl;
    int          failures = 0;
    int          tests_run = 0;
    int          cnt, tcnt, i, j;
    logic [12:0] ev_t [5] = '{13'h0001, 13'h0004, 13'h0008, 13'h0010, 13'h0040};
    logic [12:0] cl_t [5] = '{13'h0080, 13'h0100, 13'h0200, 13'h0C00, 13'h1000};
    int          en_t [5] = '{1, 2, 3, 4, 5};

    assign fl = {backup_switch_flag, |stamp_flags, alarm_flag, countdown_flag, tick_flag};

    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        tcnt <= (tcnt >= TP - 1) ? 0 : tcnt + 1;
        tick_64hz <= (tcnt >= TP - 1);
    end

    rtcs_irq rtcs_irq_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1), .tick_64hz(tick_64hz),
        .sec_inc(pl[0]), .min_inc(pl[1]), .countdown_event(pl[2]), .alarm_event(pl[3]),
        .tamper_mid_event(pl[4]), .tamper_gnd_event(pl[5]), .backup_switch_event(pl[6]),
        .watchdog_expired(lv[0]), .cell_low(lv[1]), .cur_month(cur_month), .cur_year(cur_year),
        .slow_tick_irq_en(en[0]), .sec_tick_irq_en(en[1]), .countdown_irq_en(en[2]),
        .alarm_irq_en(en[3]), .stamp_irq_en(en[4]), .backup_switch_irq_en(en[5]),
        .cell_low_irq_en(en[6]), .watchdog_irq_en(en[7]), .pulse_mode_sel(pmode),
        .backup_event_stamp_en(bstamp), .stamp_keep_first(keep),
        .clr_tick(pl[7] | host_clr[0]), .clr_countdown(pl[8] | host_clr[1]),
        .clr_alarm(pl[9] | host_clr[2]), .clr_stamp1(pl[10] | host_clr[3]),
        .clr_stamp2(pl[11] | host_clr[4]), .clr_backup(pl[12] | host_clr[5]),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .tick_flag(tick_flag),
        .countdown_flag(countdown_flag), .alarm_flag(alarm_flag), .stamp_flags(stamp_flags),
        .backup_switch_flag(backup_switch_flag), .watchdog_expired_flag(watchdog_expired_flag),
        .cell_low_flag(cell_low_flag), .stamp_month_reg(smon), .stamp_year_reg(syr));

    rtcs_host_model rtcs_host_model_inst (.ref_clk(ref_clk), .arst_n(arst_n), .irq_n_o(irq_n_o),
        .irq_n_oe(irq_n_oe), .svc_en(svc), .lat(lat), .irq_line(irq_line), .clr(host_clr));

    task automatic fire(input logic [12:0] m);
        @(posedge ref_clk);
        pl <= m;
        @(posedge ref_clk);
        pl <= '0;
    endtask : fire

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    // Random BCD date; upper month bits get noise that must not reach the stamp
    task automatic new_date;
        @(posedge ref_clk);
        cur_month <= {3'($urandom), 1'($urandom), 4'($urandom % 10)};
        cur_year  <= {4'($urandom % 10), 4'($urandom % 10)};
        #1;
    endtask : new_date

    task automatic wait_oe(input logic v);
        cnt = 0;
        while (irq_n_oe !== v && cnt < 200) begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
    endtask : wait_oe

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #500000;
        failures++;
        report_and_stop();
    end

    initial begin
        i = $urandom(34);
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        idle(2);
        `CHK(smon, STAMP_MONTH_RST)
        fire(13'h0008);
        idle(3);
        `CHK({alarm_flag, irq_line}, 2'b11)
        fire(13'h0200);
        new_date();
        bstamp <= 1'b1;
        exp_m = cur_month & MONTH_USED_MASK;
        exp_y = cur_year;
        fire(13'h0040);
        idle(3);
        `CHK({smon, syr, backup_switch_flag}, {exp_m, exp_y, 1'b1})
        new_date();
        fire(13'h0040);
        fire(13'h0020);
        idle(3);
        `CHK({smon, syr, stamp_flags}, {exp_m, exp_y, 2'h0})
        fire(13'h1000);
        idle(4);
        `CHK(backup_switch_flag, 1'b0)
        bstamp <= 1'b0;
        new_date();
        fire(13'h0040);
        idle(3);
        `CHK({smon, backup_switch_flag}, {exp_m, 1'b1})
        fire(13'h1000);
        for (i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            en <= 8'h01 << en_t[i];
            fire(ev_t[i]);
            idle(3);
            `CHK(irq_line, 1'b0)
            fire(cl_t[i]);
            idle(4);
            `CHK({fl[i], irq_line}, 2'b01)
        end
        for (j = 0; j < 2; j++) begin
            @(posedge ref_clk);
            en <= 8'h80 >> j;
            lv <= 2'h1 << j;
            idle(3);
            `CHK(irq_line, 1'b0)
            fire(13'h1F80);
            idle(3);
            `CHK({watchdog_expired_flag, cell_low_flag}, {lv[0], lv[1]})
            @(posedge ref_clk);
            lv <= '0;
            idle(4);
            `CHK(irq_line, 1'b1)
        end
        pmode <= 1'b1;
        for (j = 0; j < 2; j++) begin
            @(posedge ref_clk);
            en <= j ? 8'h04 : 8'h02;
            fire(ev_t[j]);
            wait_oe(1'b1);
            wait_oe(1'b0);
            `CHK(cnt, TP)
            fire(cl_t[j]);
            idle(3);
            fire(ev_t[j]);
            wait_oe(1'b1);
            fire(cl_t[j]);
            idle(3);
            `CHK(irq_n_oe, 1'b0)
            wait_oe(1'b0);
            idle(TP);
        end
        pmode <= 1'b0;
        svc <= 1'b1;
        repeat (30) begin
            @(posedge ref_clk);
            en   <= 8'($urandom);
            lat  <= 4'($urandom);
            keep <= 1'($urandom);
            lv   <= 2'($urandom);
            new_date();
            fire(13'($urandom) & 13'h007F);
            idle($urandom % 20);
        end
        @(posedge ref_clk);
        lv <= '0;
        idle(40);
        `CHK(irq_line, 1'b1)
        report_and_stop();
    end
endmodule : tb_top

bind rtcs_irq rtcs_irq_props rtcs_irq_props_inst (.*);

// ---- logic/rtcs_irq.sv ----
`timescale 1ns/1ps
// Operation
// RULE1 - Month stamp BCD: tens bit4, units 3..0
// RULE2 - Year stamp BCD: tens 7..4, units 3..0
// RULE3 - Stamping disabled: switch-over leaves stamps alone
// RULE4 - Enabled, flag clear: stamp, then set flag
// RULE5 - Enabled, flag set: ignore switch and tamper
// RULE6 - Open-drain active-low request, released when disabled
// RULE7 - Seven sources merged onto one request
// RULE8 - Level sources follow their flags, never pulse
// RULE9 - Host clears tick, countdown, alarm, stamp, switch
// RULE10 - Watchdog flag read-only, writes ignored
// RULE11 - Cell-low flag read-only, cleared by detector
// RULE12 - Minute and second enables are independent; here the second enable masks minute events
// RULE13 - Tick flag set per enabled increment
// RULE14 - Pulse mode pulses, else level until cleared
// RULE15 - Tick pulse lasts one 64 Hz period
// RULE16 - Countdown request gated by its enable
// RULE17 - Countdown pulses per period or follows flag
// RULE18 - Clearing flag cuts running pulse short
// RULE19 - Alarm request follows alarm flag
// RULE20 - Stamp request follows stamp flags
// RULE21 - Switch-over request follows switch flag
// RULE22 - Request is OR of all enabled sources
// RULE23 - Clear writes registered before acting on generators
module rtcs_irq
    import rtcs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic       tick_64hz,
    input  wire logic       sec_inc,
    input  wire logic       min_inc,
    input  wire logic       countdown_event,
    input  wire logic       alarm_event,
    input  wire logic       tamper_mid_event,
    input  wire logic       tamper_gnd_event,
    input  wire logic       backup_switch_event,
    input  wire logic       watchdog_expired,
    input  wire logic       cell_low,
    input  wire logic [7:0] cur_month,
    input  wire logic [7:0] cur_year,
    input  wire logic       slow_tick_irq_en,
    input  wire logic       sec_tick_irq_en,
    input  wire logic       countdown_irq_en,
    input  wire logic       alarm_irq_en,
    input  wire logic       stamp_irq_en,
    input  wire logic       backup_switch_irq_en,
    input  wire logic       cell_low_irq_en,
    input  wire logic       watchdog_irq_en,
    input  wire logic       pulse_mode_sel,
    input  wire logic       backup_event_stamp_en,
    input  wire logic       stamp_keep_first,
    input  wire logic       clr_tick,
    input  wire logic       clr_countdown,
    input  wire logic       clr_alarm,
    input  wire logic       clr_stamp1,
    input  wire logic       clr_stamp2,
    input  wire logic       clr_backup,
    output logic            irq_n_o,
    output logic            irq_n_oe,
    output logic            tick_flag,
    output logic            countdown_flag,
    output logic            alarm_flag,
    output logic [1:0]      stamp_flags,
    output logic            backup_switch_flag,
    output logic            watchdog_expired_flag,
    output logic            cell_low_flag,
    output logic [7:0]      stamp_month_reg,
    output logic [7:0]      stamp_year_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic           tick_flag_ff;
    logic           countdown_flag_ff;
    logic           alarm_flag_ff;
    logic [1:0]     stamp_flags_ff;
    logic           backup_flag_ff;
    logic           wdt_flag_ff;
    logic           cell_flag_ff;
    logic           irq_oe_ff;
    logic           irq_n_ff;
    logic [7:0]     month_out_ff;
    logic [7:0]     year_out_ff;

    logic           clr_tick_ff;
    logic           clr_cd_ff;
    logic           clr_alarm_ff;
    logic           clr_st1_ff;
    logic           clr_st2_ff;
    logic           clr_bk_ff;

    rtcs_pulse_st_t tick_st_ff;
    rtcs_pulse_st_t nxt_tick_st;
    rtcs_pulse_st_t cd_st_ff;
    rtcs_pulse_st_t nxt_cd_st;
    logic [1:0]     tick_cnt_ff;
    logic [1:0]     cd_cnt_ff;

    logic           tick_set;
    logic           stamp_frozen;
    logic           bk_stamp;
    logic           ts_accept;
    logic           ts_store;
    logic           tick_req;
    logic           cd_req;
    logic           irq_any;

    rtcs_stamp_if   stamp_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Clear strobes

    // Clears are captured once so every generator sees the same clean strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_tick_ff  <= 1'b0;
            clr_cd_ff    <= 1'b0;
            clr_alarm_ff <= 1'b0;
            clr_st1_ff   <= 1'b0;
            clr_st2_ff   <= 1'b0;
            clr_bk_ff    <= 1'b0;
        end else if (clk_en) begin
            clr_tick_ff  <= clr_tick; // RULE23
            clr_cd_ff    <= clr_countdown; // RULE23
            clr_alarm_ff <= clr_alarm;
            clr_st1_ff   <= clr_stamp1;
            clr_st2_ff   <= clr_stamp2;
            clr_bk_ff    <= clr_backup;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event qualification

    // Second enable dominates, so a coincident minute event adds nothing
    assign tick_set = (sec_tick_irq_en && sec_inc) || // RULE12
                      (slow_tick_irq_en && !sec_tick_irq_en && min_inc); // RULE13

    assign stamp_frozen = backup_event_stamp_en && backup_flag_ff;
    assign bk_stamp     = backup_switch_event && backup_event_stamp_en && !backup_flag_ff; // RULE4
    assign ts_accept    = (tamper_mid_event || tamper_gnd_event) && !stamp_frozen; // RULE5
    // In keep-first mode a pending stamp is not overwritten by later tamper events
    assign ts_store     = (ts_accept && !(stamp_keep_first && (stamp_flags_ff != 2'h0))) ||
                          bk_stamp; // RULE3

    ////////////////////////////////////////////////////////////////////////////
    // Flags, set wins over clear

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_flag_ff <= FLAG_RST;
        end else if (clk_en) begin
            if (tick_set) begin
                tick_flag_ff <= 1'b1; // RULE13
            end else if (clr_tick_ff) begin
                tick_flag_ff <= 1'b0; // RULE9
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            countdown_flag_ff <= FLAG_RST;
        end else if (clk_en) begin
            if (countdown_event) begin
                countdown_flag_ff <= 1'b1;
            end else if (clr_cd_ff) begin
                countdown_flag_ff <= 1'b0; // RULE9
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_flag_ff <= FLAG_RST;
        end else if (clk_en) begin
            if (alarm_event) begin
                alarm_flag_ff <= 1'b1;
            end else if (clr_alarm_ff) begin
                alarm_flag_ff <= 1'b0; // RULE9
            end
        end
    end

    // Bit 0 marks any tamper event, bit 1 only the grounded one
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stamp_flags_ff <= 2'h0;
        end else if (clk_en) begin
            if (ts_accept) begin
                stamp_flags_ff[0] <= 1'b1; // RULE5
            end else if (clr_st1_ff) begin
                stamp_flags_ff[0] <= 1'b0; // RULE9
            end
            if (ts_accept && tamper_gnd_event) begin
                stamp_flags_ff[1] <= 1'b1;
            end else if (clr_st2_ff) begin
                stamp_flags_ff[1] <= 1'b0; // RULE9
            end
        end
    end

    // Switch-over flag rises on every switch-over, stamping or not
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            backup_flag_ff <= FLAG_RST;
        end else if (clk_en) begin
            if (backup_switch_event) begin
                backup_flag_ff <= 1'b1; // RULE4
            end else if (clr_bk_ff) begin
                backup_flag_ff <= 1'b0; // RULE9
            end
        end
    end

    // Read-only flags mirror their sources; no host clear path exists
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wdt_flag_ff  <= FLAG_RST;
            cell_flag_ff <= FLAG_RST;
        end else if (clk_en) begin
            wdt_flag_ff  <= watchdog_expired; // RULE10
            cell_flag_ff <= cell_low; // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timestamp capture

    assign stamp_bus.wr_en    = ts_store && clk_en;
    assign stamp_bus.wr_month = cur_month;
    assign stamp_bus.wr_year  = cur_year;

    rtcs_stamp_mem u_stamp_mem (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .st      (stamp_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pulse generators

    // A pulse waits for the next 64 Hz edge so its width is one full period
    always_comb begin
        nxt_tick_st = tick_st_ff;
        case (tick_st_ff)
            RTCS_PULSE_IDLE: begin
                if (tick_set && pulse_mode_sel) begin
                    nxt_tick_st = RTCS_PULSE_WAIT;
                end
            end
            RTCS_PULSE_WAIT: begin
                if (!tick_flag_ff || clr_tick_ff) begin
                    nxt_tick_st = RTCS_PULSE_IDLE; // RULE18
                end else if (tick_64hz) begin
                    nxt_tick_st = RTCS_PULSE_ACTIVE; // RULE15
                end
            end
            RTCS_PULSE_ACTIVE: begin
                if (clr_tick_ff) begin
                    nxt_tick_st = RTCS_PULSE_IDLE; // RULE18
                end else if (tick_64hz && tick_cnt_ff == PULSE_TICKS) begin
                    nxt_tick_st = RTCS_PULSE_IDLE; // RULE15
                end
            end
            default: begin
                nxt_tick_st = RTCS_PULSE_IDLE;
            end
        endcase
    end

    always_comb begin
        nxt_cd_st = cd_st_ff;
        case (cd_st_ff)
            RTCS_PULSE_IDLE: begin
                if (countdown_event && pulse_mode_sel) begin
                    nxt_cd_st = RTCS_PULSE_WAIT; // RULE17
                end
            end
            RTCS_PULSE_WAIT: begin
                if (!countdown_flag_ff || clr_cd_ff) begin
                    nxt_cd_st = RTCS_PULSE_IDLE; // RULE18
                end else if (tick_64hz) begin
                    nxt_cd_st = RTCS_PULSE_ACTIVE;
                end
            end
            RTCS_PULSE_ACTIVE: begin
                if (clr_cd_ff) begin
                    nxt_cd_st = RTCS_PULSE_IDLE; // RULE18
                end else if (tick_64hz && cd_cnt_ff == PULSE_TICKS) begin
                    nxt_cd_st = RTCS_PULSE_IDLE;
                end
            end
            default: begin
                nxt_cd_st = RTCS_PULSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_st_ff <= RTCS_PULSE_IDLE;
            cd_st_ff   <= RTCS_PULSE_IDLE;
        end else if (clk_en) begin
            tick_st_ff <= nxt_tick_st;
            cd_st_ff   <= nxt_cd_st;
        end
    end

    // Counts 64 Hz edges seen while the pulse is active
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_ff <= 2'h0;
            cd_cnt_ff   <= 2'h0;
        end else if (clk_en) begin
            if (nxt_tick_st != RTCS_PULSE_ACTIVE) begin
                tick_cnt_ff <= 2'h0;
            end else if (tick_st_ff == RTCS_PULSE_WAIT) begin
                tick_cnt_ff <= 2'h1;
            end else if (tick_64hz) begin
                tick_cnt_ff <= tick_cnt_ff + 2'h1;
            end
            if (nxt_cd_st != RTCS_PULSE_ACTIVE) begin
                cd_cnt_ff <= 2'h0;
            end else if (cd_st_ff == RTCS_PULSE_WAIT) begin
                cd_cnt_ff <= 2'h1;
            end else if (cd_64hz_step(tick_64hz)) begin
                cd_cnt_ff <= cd_cnt_ff + 2'h1;
            end
        end
    end

    function automatic logic cd_64hz_step(input logic t);
        return t;
    endfunction : cd_64hz_step

    ////////////////////////////////////////////////////////////////////////////
    // Request merge

    assign tick_req = (slow_tick_irq_en || sec_tick_irq_en) &&
                      (pulse_mode_sel ? (tick_st_ff == RTCS_PULSE_ACTIVE) : tick_flag_ff); // RULE14
    assign cd_req   = countdown_irq_en && // RULE16
                      (pulse_mode_sel ? (cd_st_ff == RTCS_PULSE_ACTIVE) : countdown_flag_ff); // RULE17

    assign irq_any = tick_req || cd_req || // RULE7
                     (watchdog_irq_en && wdt_flag_ff) || // RULE8
                     (alarm_irq_en && alarm_flag_ff) || // RULE19
                     (stamp_irq_en && (stamp_flags_ff != 2'h0)) || // RULE20
                     (backup_switch_irq_en && backup_flag_ff) || // RULE21
                     (cell_low_irq_en && cell_flag_ff); // RULE22

    // Pin only ever pulls low; released means not driven
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_oe_ff <= 1'b0;
            irq_n_ff  <= 1'b0;
        end else if (clk_en) begin
            irq_oe_ff <= irq_any; // RULE6
            irq_n_ff  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Stamp values re-registered so every output leaves a flip-flop
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            month_out_ff <= STAMP_MONTH_RST;
            year_out_ff  <= STAMP_YEAR_RST;
        end else if (clk_en) begin
            month_out_ff <= stamp_bus.rd_month;
            year_out_ff  <= stamp_bus.rd_year;
        end
    end

    assign irq_n_o               = irq_n_ff;
    assign irq_n_oe              = irq_oe_ff;
    assign tick_flag             = tick_flag_ff;
    assign countdown_flag        = countdown_flag_ff;
    assign alarm_flag            = alarm_flag_ff;
    assign stamp_flags           = stamp_flags_ff;
    assign backup_switch_flag    = backup_flag_ff;
    assign watchdog_expired_flag = wdt_flag_ff;
    assign cell_low_flag         = cell_flag_ff;
    assign stamp_month_reg       = month_out_ff;
    assign stamp_year_reg        = year_out_ff;

endmodule : rtcs_irq

// ---- logic/rtcs_stamp_mem.sv ----
`timescale 1ns/1ps
module rtcs_stamp_mem
    import rtcs_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    rtcs_stamp_if.mem st
);

    logic [7:0] month_ff;
    logic [7:0] year_ff;

    // Unused month bits are forced to zero so they always read as zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            month_ff <= STAMP_MONTH_RST;
        end else if (clk_en && st.wr_en) begin
            month_ff <= st.wr_month & MONTH_USED_MASK; // RULE1
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            year_ff <= STAMP_YEAR_RST;
        end else if (clk_en && st.wr_en) begin
            year_ff <= st.wr_year & YEAR_USED_MASK; // RULE2
        end
    end

    assign st.rd_month = month_ff;
    assign st.rd_year  = year_ff;

endmodule : rtcs_stamp_mem

// ---- pkg/rtcs_pkg.sv ----
package rtcs_pkg;

    // Timestamp register offsets
    localparam logic [7:0] STAMP_MONTH_OFS  = 8'h17;
    localparam logic [7:0] STAMP_YEAR_OFS   = 8'h18;

    // Field layout of the captured month
    localparam int         MONTH_TENS_POS   = 4;
    localparam logic [7:0] MONTH_USED_MASK  = 8'h1F;

    // Field layout of the captured year
    localparam int         YEAR_TENS_LSB    = 4;
    localparam logic [7:0] YEAR_USED_MASK   = 8'hFF;

    // Values after reset
    localparam logic [7:0] STAMP_MONTH_RST  = 8'h00;
    localparam logic [7:0] STAMP_YEAR_RST   = 8'h00;
    localparam logic       FLAG_RST         = 1'b0;

    // Interrupt pulse lasts this many 64 Hz ticks
    localparam logic [1:0] PULSE_TICKS      = 2'h1;

    typedef enum logic [1:0] {
        RTCS_PULSE_IDLE,
        RTCS_PULSE_WAIT,
        RTCS_PULSE_ACTIVE
    } rtcs_pulse_st_t;

endpackage : rtcs_pkg

// ---- pkg/rtcs_stamp_if.sv ----
`timescale 1ns/1ps
interface rtcs_stamp_if;
    logic       wr_en;
    logic [7:0] wr_month;
    logic [7:0] wr_year;
    logic [7:0] rd_month;
    logic [7:0] rd_year;

    modport ctrl (output wr_en, output wr_month, output wr_year, input rd_month, input rd_year);
    modport mem  (input wr_en, input wr_month, input wr_year, output rd_month, output rd_year);
endinterface : rtcs_stamp_if
